// >>> common/hdip_pkg.sv
// constants, encodings and decode helpers of the host data input port
// Behaviour
// - three serial setting sets are kept and any one is recalled as active
// - serial rates 300, 600, 1200, 2400, 4800, 9600, 19200 bit/s
// - format is seven or eight data bits with even, odd or no parity
// - a new rate or format is pending until confirmed; old one stays active
// - on strobe the port raises busy, pulses ack, then captures the data
// - after the byte is handled busy drops and the port waits again
// - the parallel port only receives; it never drives data lines
// - transfers paced by strobe and busy; no strobe while busy
// - serial side is a terminal: holds txd at mark, drives rts/dtr, senses cts/dsr/dcd
package hdip_pkg;
   localparam int BYTE_W   = 8;
   localparam int ADDR_W   = 5;
   localparam int CNT_W    = 20;
   localparam int CLK_MHZ  = 200;
   localparam int NSETS    = 3;
   localparam int BUSY_NS  = 100;
   localparam int ACK_NS   = 500;
   localparam int BUSY_CYC = (BUSY_NS * CLK_MHZ + 999) / 1000;
   localparam int ACK_CYC  = (ACK_NS * CLK_MHZ + 999) / 1000;
   // register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS  = 5'h00;
   localparam logic [ADDR_W-1:0] PEND_OFS  = 5'h04;
   localparam logic [ADDR_W-1:0] CMD_OFS   = 5'h08;
   localparam logic [ADDR_W-1:0] ACT_OFS   = 5'h0C;
   localparam logic [ADDR_W-1:0] STAT_OFS  = 5'h10;
   localparam logic [ADDR_W-1:0] PDATA_OFS = 5'h14;
   localparam logic [ADDR_W-1:0] SDATA_OFS = 5'h18;
   // field positions
   localparam int CONFIRM_BIT = 4;
   localparam int RECALL_BIT  = 5;
   // reset values and legal limits of rate and format codes
   localparam logic [2:0] RATE_RST = 3'h5;
   localparam logic [2:0] FMT_RST  = 3'h2;
   localparam logic [2:0] RATE_MAX = 3'h6;
   localparam logic [2:0] FMT_MAX  = 3'h5;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;

   // clock cycles per serial bit for a rate code
   function automatic logic [CNT_W-1:0] bit_cycles(input int clk_hz, input logic [2:0] code);
      unique case (code)
         3'h0: bit_cycles = CNT_W'(clk_hz / 300);
         3'h1: bit_cycles = CNT_W'(clk_hz / 600);
         3'h2: bit_cycles = CNT_W'(clk_hz / 1200);
         3'h3: bit_cycles = CNT_W'(clk_hz / 2400);
         3'h4: bit_cycles = CNT_W'(clk_hz / 4800);
         3'h5: bit_cycles = CNT_W'(clk_hz / 9600);
         default: bit_cycles = CNT_W'(clk_hz / 19200);
      endcase
   endfunction : bit_cycles

   // format codes: 0 8E, 1 8O, 2 8N, 3 7E, 4 7O, 5 7N
   function automatic logic fmt_seven(input logic [2:0] f);
      fmt_seven = (f >= 3'h3);
   endfunction : fmt_seven

   function automatic logic fmt_par(input logic [2:0] f);
      fmt_par = (f != 3'h2) && (f != 3'h5);
   endfunction : fmt_par

   function automatic logic fmt_odd(input logic [2:0] f);
      fmt_odd = (f == 3'h1) || (f == 3'h4);
   endfunction : fmt_odd
endpackage : hdip_pkg

// >>> hdl/byte_fifo.sv
// small first-in first-out store with a registered read port
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             aclk,
   input  wire logic             aresetn,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      cnt_q;
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic             push;
   logic             load;

   // output stage refills whenever it is empty or being drained
   assign in_ready = ((AW+1)'(cnt_q + out_valid) != (AW+1)'(DEPTH)); // output register is one of the DEPTH words
   assign push     = in_valid && in_ready;
   assign load     = (cnt_q != '0) && (!out_valid || out_ready);

   always_ff @(posedge aclk) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wp_q      <= '0;
         rp_q      <= '0;
         cnt_q     <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         if (push) begin
            wp_q <= AW'(wp_q + 1'b1);
         end
         if (load) begin
            rp_q     <= AW'(rp_q + 1'b1);
            out_data <= mem_q[rp_q];
         end
         if (push && !load) begin
            cnt_q <= (AW+1)'(cnt_q + 1'b1);
         end else if (load && !push) begin
            cnt_q <= (AW+1)'(cnt_q - 1'b1);
         end
         if (load) begin
            out_valid <= 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule : byte_fifo

// >>> hdl/serial_rx.sv
// asynchronous start-stop character receiver
`timescale 1ns/1ps
module serial_rx #(
   parameter int CLK_HZ = 200_000_000
) (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   input  wire logic                        rxd_s,
   input  wire logic [2:0]                  cfg_rate,
   input  wire logic [2:0]                  cfg_fmt,
   output logic      [hdip_pkg::BYTE_W-1:0] rx_byte,
   output logic                             rx_valid,
   output logic                             rx_perr,
   output logic                             rx_ferr
);
   import hdip_pkg::*;
   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} rx_st_t;
   rx_st_t           st_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] per_q;
   logic [2:0]       fmt_q;
   logic [2:0]       n_q;
   logic             tick;

   assign tick = (cnt_q == '0);

   // settings are caught at the start edge so a change never splits a character
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q     <= S_IDLE;
         cnt_q    <= '0;
         per_q    <= '0;
         fmt_q    <= FMT_RST;
         n_q      <= '0;
         rx_byte  <= '0;
         rx_valid <= 1'b0;
         rx_perr  <= 1'b0;
         rx_ferr  <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (!tick) begin
            cnt_q <= CNT_W'(cnt_q - 1'b1);
         end
         unique case (st_q)
            S_IDLE: if (!rxd_s) begin
               per_q <= bit_cycles(CLK_HZ, cfg_rate);
               fmt_q <= cfg_fmt;
               cnt_q <= CNT_W'(bit_cycles(CLK_HZ, cfg_rate) >> 1);
               st_q  <= S_START;
            end
            S_START: if (tick) begin
               // a glitch shorter than half a bit is dropped
               st_q    <= rxd_s ? S_IDLE : S_DATA;
               cnt_q   <= CNT_W'(per_q - 1'b1);
               n_q     <= '0;
               rx_byte <= '0;
            end
            S_DATA: if (tick) begin
               rx_byte[n_q] <= rxd_s;
               n_q          <= 3'(n_q + 1'b1);
               cnt_q        <= CNT_W'(per_q - 1'b1);
               if (n_q == (fmt_seven(fmt_q) ? 3'h6 : 3'h7)) begin
                  st_q <= fmt_par(fmt_q) ? S_PAR : S_STOP;
               end
            end
            S_PAR: if (tick) begin
               rx_perr <= rxd_s != ((^rx_byte) ^ fmt_odd(fmt_q));
               cnt_q   <= CNT_W'(per_q - 1'b1);
               st_q    <= S_STOP;
            end
            S_STOP: if (tick) begin
               if (!fmt_par(fmt_q)) begin
                  rx_perr <= 1'b0;
               end
               rx_ferr  <= !rxd_s;
               rx_valid <= 1'b1;
               st_q     <= S_IDLE;
            end
         endcase
      end
   end

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_CFG_HELD: assert property (st_q != S_IDLE |=> $stable(per_q) && $stable(fmt_q))
      else $error("receiver settings changed inside a character");
   AST_VALID_AT_STOP: assert property (rx_valid |-> $past(st_q) == S_STOP && st_q == S_IDLE)
      else $error("character delivered outside the stop bit");
endmodule : serial_rx

// >>> hdl/host_data_input_port.sv
// parallel receive port, serial settings store and register slave
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module host_data_input_port #(
   parameter int CLK_HZ     = 200_000_000,
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic                        aclk,
   input  wire logic                        aresetn,
   // parallel port pins
   input  wire logic                        strobe_n,
   input  wire logic [hdip_pkg::BYTE_W-1:0] data_in,
   output logic                             busy,
   output logic                             ack_n,
   // serial port pins
   input  wire logic                        rxd,
   output logic                             txd,
   output logic                             rts,
   output logic                             dtr,
   input  wire logic                        cts,
   input  wire logic                        dsr,
   input  wire logic                        dcd,
   // register bus
   input  wire logic [hdip_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                        s_axi_awvalid,
   output logic                             s_axi_awready,
   input  wire logic [31:0]                 s_axi_wdata,
   input  wire logic [3:0]                  s_axi_wstrb,
   input  wire logic                        s_axi_wvalid,
   output logic                             s_axi_wready,
   output logic      [1:0]                  s_axi_bresp,
   output logic                             s_axi_bvalid,
   input  wire logic                        s_axi_bready,
   input  wire logic [hdip_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                        s_axi_arvalid,
   output logic                             s_axi_arready,
   output logic      [31:0]                 s_axi_rdata,
   output logic      [1:0]                  s_axi_rresp,
   output logic                             s_axi_rvalid,
   input  wire logic                        s_axi_rready
);
   import hdip_pkg::*;
   typedef enum logic [2:0] {P_IDLE, P_BUSY, P_ACK, P_PUSH, P_WAIT} par_st_t;

   par_st_t          pst_q;
   logic [7:0]       pcnt_q;
   logic [BYTE_W-1:0] data_s1_q, data_s2_q, pbyte_q;
   logic [2:0]       stb_q;
   logic [1:0]       rxd_q;
   logic [2:0]       mdm_s1_q, mdm_s2_q;
   logic             fell_stb;
   logic             push_v, push_rdy;
   logic             pop_v;
   logic [BYTE_W-1:0] pop_d;
   logic             rd_pdata;
   logic [2:0]       pend_rate_q, pend_fmt_q, act_rate_q, act_fmt_q;
   logic [1:0]       act_idx_q;
   logic [2:0]       set_rate_q [NSETS];
   logic [2:0]       set_fmt_q  [NSETS];
   logic [BYTE_W-1:0] rx_byte, sbyte_q;
   logic             rx_valid, rx_perr, rx_ferr;
   logic             svalid_q, perr_q, ferr_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0]      w_data_q;
   logic [3:0]       w_strb_q;
   logic             aw_full_q, w_full_q;
   logic             take_aw, take_w, take_ar, wr_fire, rd_sdata;
   logic [1:0]       cidx;

   // offsets answered by the slave; used by both read and write paths
   function automatic logic ofs_known(input logic [ADDR_W-1:0] a);
      ofs_known = (a == CTRL_OFS) || (a == PEND_OFS) || (a == CMD_OFS) || (a == ACT_OFS) ||
                  (a == STAT_OFS) || (a == PDATA_OFS) || (a == SDATA_OFS);
   endfunction : ofs_known

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the second stage feeds logic, and the strobe edge also uses the third
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stb_q     <= 3'h7;
         data_s1_q <= '0;
         data_s2_q <= '0;
         rxd_q     <= 2'h3;
         mdm_s1_q  <= '0;
         mdm_s2_q  <= '0;
      end else begin
         stb_q     <= {stb_q[1:0], strobe_n};
         data_s1_q <= data_in;
         data_s2_q <= data_s1_q;
         rxd_q     <= {rxd_q[0], rxd};
         mdm_s1_q  <= {dcd, dsr, cts};
         mdm_s2_q  <= mdm_s1_q;
      end
   end

   assign fell_stb = stb_q[2] && !stb_q[1];

   ////////////////////////////////////////////////////////////////////////
   // parallel handshake: busy, ack pulse, capture, push, wait strobe high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pst_q   <= P_IDLE;
         pcnt_q  <= '0;
         busy    <= 1'b0;
         ack_n   <= 1'b1;
         pbyte_q <= '0;
      end else begin
         if (pcnt_q != '0) begin
            pcnt_q <= 8'(pcnt_q - 1'b1);
         end
         unique case (pst_q)
            P_IDLE: if (fell_stb) begin
               busy   <= 1'b1;
               pcnt_q <= 8'(BUSY_CYC - 1);
               pst_q  <= P_BUSY;
            end
            P_BUSY: if (pcnt_q == '0) begin
               ack_n  <= 1'b0;
               pcnt_q <= 8'(ACK_CYC - 1);
               pst_q  <= P_ACK;
            end
            P_ACK: if (pcnt_q == '0) begin
               ack_n   <= 1'b1;
               pbyte_q <= data_s2_q;
               pst_q   <= P_PUSH;
            end
            // a full store holds busy high, stalling the host
            P_PUSH: if (push_rdy) begin
               pst_q <= P_WAIT;
            end
            // strobes while busy are not looked at
            P_WAIT: if (stb_q[1]) begin
               busy  <= 1'b0;
               pst_q <= P_IDLE;
            end
         endcase
      end
   end

   assign push_v = (pst_q == P_PUSH);

   byte_fifo #(
      .WIDTH (BYTE_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .in_valid  (push_v),
      .in_data   (pbyte_q),
      .in_ready  (push_rdy),
      .out_valid (pop_v),
      .out_data  (pop_d),
      .out_ready (rd_pdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // serial receiver and its result flags; an arriving byte beats a clearing read
   serial_rx #(
      .CLK_HZ (CLK_HZ)
   ) u_rx (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .rxd_s    (rxd_q[1]),
      .cfg_rate (act_rate_q),
      .cfg_fmt  (act_fmt_q),
      .rx_byte  (rx_byte),
      .rx_valid (rx_valid),
      .rx_perr  (rx_perr),
      .rx_ferr  (rx_ferr)
   );

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sbyte_q  <= '0;
         svalid_q <= 1'b0;
         perr_q   <= 1'b0;
         ferr_q   <= 1'b0;
      end else if (rx_valid) begin
         sbyte_q  <= rx_byte;
         svalid_q <= 1'b1;
         perr_q   <= rx_perr;
         ferr_q   <= rx_ferr;
      end else if (rd_sdata) begin
         svalid_q <= 1'b0;
         perr_q   <= 1'b0;
         ferr_q   <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register bus: address and data taken in either order, then one response
   assign take_aw  = s_axi_awready && s_axi_awvalid;
   assign take_w   = s_axi_wready && s_axi_wvalid;
   assign take_ar  = s_axi_arready && s_axi_arvalid;
   assign wr_fire  = aw_full_q && w_full_q && !s_axi_bvalid;
   assign rd_pdata = take_ar && (s_axi_araddr == PDATA_OFS);
   assign rd_sdata = take_ar && (s_axi_araddr == SDATA_OFS);
   assign cidx     = w_data_q[1:0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q     <= 1'b0;
         w_full_q      <= 1'b0;
         aw_addr_q     <= '0;
         w_data_q      <= '0;
         w_strb_q      <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OK;
      end else begin
         if (take_aw) begin
            aw_addr_q <= s_axi_awaddr;
         end
         if (take_w) begin
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         aw_full_q     <= take_aw || (aw_full_q && !wr_fire);
         w_full_q      <= take_w || (w_full_q && !wr_fire);
         s_axi_awready <= !aw_full_q && !take_aw && !s_axi_bvalid && !wr_fire;
         s_axi_wready  <= !w_full_q && !take_w && !s_axi_bvalid && !wr_fire;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= ofs_known(aw_addr_q) ? RESP_OK : RESP_ERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // register write effects; unknown codes leave the pending value alone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rts         <= 1'b0;
         dtr         <= 1'b0;
         txd         <= 1'b1;
         pend_rate_q <= RATE_RST;
         pend_fmt_q  <= FMT_RST;
         act_rate_q  <= RATE_RST;
         act_fmt_q   <= FMT_RST;
         act_idx_q   <= '0;
         for (int i = 0; i < NSETS; i++) begin
            set_rate_q[i] <= RATE_RST;
            set_fmt_q[i]  <= FMT_RST;
         end
      end else if (wr_fire && w_strb_q[0]) begin
         unique case (aw_addr_q)
            CTRL_OFS: begin
               rts <= w_data_q[0];
               dtr <= w_data_q[1];
            end
            PEND_OFS: begin
               if (w_data_q[2:0] <= RATE_MAX) begin
                  pend_rate_q <= w_data_q[2:0];
               end
               if (w_data_q[5:3] <= FMT_MAX) begin
                  pend_fmt_q <= w_data_q[5:3];
               end
            end
            CMD_OFS: if (cidx < 2'(NSETS)) begin
               if (w_data_q[CONFIRM_BIT]) begin
                  set_rate_q[cidx] <= pend_rate_q;
                  set_fmt_q[cidx]  <= pend_fmt_q;
                  act_rate_q       <= pend_rate_q;
                  act_fmt_q        <= pend_fmt_q;
                  act_idx_q        <= cidx;
               end else if (w_data_q[RECALL_BIT]) begin
                  act_rate_q <= set_rate_q[cidx];
                  act_fmt_q  <= set_fmt_q[cidx];
                  act_idx_q  <= cidx;
               end
            end
            default: ;
         endcase
      end
   end

   // reads: data registers pop or clear as a side effect of the read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OK;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !take_ar;
         if (take_ar) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= ofs_known(s_axi_araddr) ? RESP_OK : RESP_ERR;
            unique case (s_axi_araddr)
               CTRL_OFS:  s_axi_rdata <= {30'h0, dtr, rts};
               PEND_OFS:  s_axi_rdata <= {26'h0, pend_fmt_q, pend_rate_q};
               ACT_OFS:   s_axi_rdata <= {22'h0, act_idx_q, 2'h0, act_fmt_q, act_rate_q};
               STAT_OFS:  s_axi_rdata <= {24'h0, mdm_s2_q, ferr_q, perr_q, svalid_q, pop_v, busy};
               PDATA_OFS: s_axi_rdata <= {23'h0, pop_v, pop_d};
               SDATA_OFS: s_axi_rdata <= {23'h0, svalid_q, sbyte_q};
               default:   s_axi_rdata <= 32'h0000_0000;
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_BUSY_ON_STROBE: assert property (pst_q == P_IDLE && fell_stb |=> busy && ack_n)
      else $error("busy not raised on strobe");
   AST_ACK_IN_BUSY: assert property ($fell(ack_n) |-> busy && pst_q == P_ACK)
      else $error("ack pulsed outside busy");
   AST_ACK_WIDTH: assert property ($fell(ack_n) |-> ##100 $rose(ack_n))
      else $error("ack pulse width wrong");
   AST_CAPTURE_AFTER_ACK: assert property (push_v |-> ack_n && busy && $past(pst_q) != P_IDLE)
      else $error("byte stored before ack");
   AST_BUSY_RELEASE: assert property ($fell(busy) |-> $past(pst_q) == P_WAIT && $past(stb_q[1]))
      else $error("busy released early");
   AST_ACTIVE_ONLY_CMD: assert property ($changed(act_rate_q) || $changed(act_fmt_q)
      |-> $past(wr_fire) && $past(aw_addr_q) == CMD_OFS)
      else $error("active setting changed without a command");
   AST_RATE_LEGAL: assert property (act_rate_q <= RATE_MAX && pend_rate_q <= RATE_MAX)
      else $error("illegal rate code");
   AST_FMT_LEGAL: assert property (act_fmt_q <= FMT_MAX && pend_fmt_q <= FMT_MAX)
      else $error("illegal format code");
endmodule : host_data_input_port

// >>> sim/host_model.sv
// host side model: parallel byte sender and serial character sender
`timescale 1ns/1ps
module host_model (
   input  wire logic       aclk,
   input  wire logic       busy,
   input  wire logic       ack_n,
   output logic            strobe_n,
   output logic      [7:0] data_in,
   output logic            rxd
);
   int n;
   // idle lines: strobe released, serial line at mark
   initial begin
      strobe_n = 1'b1;
      data_in  = 8'h00;
      rxd      = 1'b1;
   end
   ////////////////////////////////////////////////////////////
   // data held from strobe fall to ack end, so capture never sees a change
   task automatic send(input logic [7:0] b, output logic ok);
      for (n = 0; busy && n < 400; n++) @(posedge aclk);
      data_in <= b;
      @(posedge aclk);
      strobe_n <= 1'b0;
      for (n = 0; ack_n && n < 400; n++) @(posedge aclk);
      for (n = 0; !ack_n && n < 400; n++) @(posedge aclk);
      ok = (n < 400);
      strobe_n <= 1'b1;
      data_in  <= ~b; // released lines do not keep the byte
   endtask : send
   ////////////////////////////////////////////////////////////
   // frame bits sent lsb first, each for cyc clocks
   task automatic ser(input logic [10:0] f, input int len, input int cyc);
      for (int i = 0; i < len; i++) begin
         rxd <= f[i];
         repeat (cyc) @(posedge aclk);
      end
      rxd <= 1'b1;
   endtask : ser
endmodule : host_model

// >>> sim/tb_host_data_input_port.sv
// self-checking bench of the host data input port
`timescale 1ns/1ps
module tb_host_data_input_port;
   import hdip_pkg::*;
   localparam int BITC = 100; // cycles per bit at 19200 with the reduced clock rate
   logic aclk = 0, aresetn = 0, cts = 0, dsr = 0, dcd = 0;
   logic busy, ack_n, strobe_n, rxd, txd, rts, dtr, ok, p;
   logic [7:0] data_in, sb, pb [17];
   logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [33:0] rq [$];
   logic [1:0] bq [$];
   int checks = 0, failures = 0, n, seed;
   logic [2:0] f;

   host_data_input_port #(.CLK_HZ(1_920_000), .FIFO_DEPTH(16)) i_dut (
      .aclk(aclk), .aresetn(aresetn), .strobe_n(strobe_n), .data_in(data_in), .busy(busy), .ack_n(ack_n),
      .rxd(rxd), .txd(txd), .rts(rts), .dtr(dtr), .cts(cts), .dsr(dsr), .dcd(dcd),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   host_model i_host (.aclk(aclk), .busy(busy), .ack_n(ack_n), .strobe_n(strobe_n), .data_in(data_in), .rxd(rxd));

   always #2.5 aclk = ~aclk;
   ////////////////////////////////////////////////////////////
   task automatic print_verdict();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   task automatic stop();
      failures++;
      print_verdict();
   endtask : stop

   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   ////////////////////////////////////////////////////////////
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      bq.push_back(r);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 100) stop();
   endtask : wr

   task automatic rd(input logic [4:0] a, input logic [33:0] e);
      @(posedge aclk);
      rq.push_back(e);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (n == 100) stop();
   endtask : rd

   function automatic logic [33:0] act(input logic [1:0] i, input logic [2:0] fm, input logic [2:0] r);
      return {RESP_OK, 22'h0, i, 2'h0, fm, r};
   endfunction : act
   ////////////////////////////////////////////////////////////
   // watcher: every answer taken off the bus meets the oldest note
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) chk("rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (s_axi_bvalid && s_axi_bready) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
   end
   ////////////////////////////////////////////////////////////
   initial begin
      seed = 32'h16ED;
      {dcd, dsr, cts} = 3'($random(seed));
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(ACT_OFS, act(2'h0, FMT_RST, RATE_RST));
      // every rate and format code, pending first, then stored in set 2
      for (int i = 0; i < 7; i++) begin
         f = 3'(i % 6);
         wr(PEND_OFS, {26'h0, f, 3'(i)}, RESP_OK);
         rd(ACT_OFS, (i == 0) ? act(2'h0, FMT_RST, RATE_RST) : act(2'h2, 3'((i - 1) % 6), 3'(i - 1)));
         wr(CMD_OFS, 32'h12, RESP_OK);
         rd(ACT_OFS, act(2'h2, f, 3'(i)));
      end
      wr(CMD_OFS, 32'h20, RESP_OK);
      rd(ACT_OFS, act(2'h0, FMT_RST, RATE_RST));
      wr(CMD_OFS, 32'h22, RESP_OK);
      rd(ACT_OFS, act(2'h2, 3'h0, 3'h6));
      rd(5'h1C, {RESP_ERR, 32'h0});
      wr(5'h1C, 32'h3, RESP_ERR);
      wr(CTRL_OFS, 32'h3, RESP_OK);
      chk("txd_dtr_rts", 34'h7, {31'h0, txd, dtr, rts});
      rd(CTRL_OFS, {RESP_OK, 32'h3});
      // sixteen bytes fill the buffer, the seventeenth is held with busy up
      for (int k = 0; k < 17; k++) begin
         pb[k] = 8'($random(seed));
         i_host.send(pb[k], ok);
         if (!ok) stop();
      end
      rd(STAT_OFS, {RESP_OK, 24'h0, dcd, dsr, cts, 5'h3});
      for (int k = 0; k < 17; k++) rd(PDATA_OFS, {RESP_OK, 23'h0, 1'b1, pb[k]});
      rd(STAT_OFS, {RESP_OK, 24'h0, dcd, dsr, cts, 5'h0});
      // serial at 19200, eight bits even parity; second frame has a wrong parity bit
      sb = 8'($random(seed));
      p  = ^sb;
      i_host.ser({1'b1, p, sb, 1'b0}, 11, BITC);
      repeat (BITC) @(posedge aclk);
      rd(SDATA_OFS, {RESP_OK, 23'h0, 1'b1, sb});
      i_host.ser({1'b1, ~p, sb, 1'b0}, 11, BITC);
      repeat (BITC) @(posedge aclk);
      rd(STAT_OFS, {RESP_OK, 24'h0, dcd, dsr, cts, 5'hC});
      // seven bits odd parity, confirmed into set 1 between characters
      wr(PEND_OFS, 32'h26, RESP_OK);
      wr(CMD_OFS, 32'h11, RESP_OK);
      i_host.ser(11'({1'b1, ~^sb[6:0], sb[6:0], 1'b0}), 10, BITC);
      repeat (BITC) @(posedge aclk);
      rd(SDATA_OFS, {RESP_OK, 23'h0, 1'b1, 1'b0, sb[6:0]});
      repeat (5) @(posedge aclk);
      print_verdict();
   end
endmodule : tb_host_data_input_port
